// ===== hdl/acrb_map.vh
// Register offsets, field positions and reset values of the converter control bank
`ifndef ACRB_MAP_VH
`define ACRB_MAP_VH
`define ACRB_OFS_CHANNEL_SELECT 12'h005
`define ACRB_OFS_POWER_MODE 12'h008
`define ACRB_OFS_ENHANCEMENT 12'h00C
`define ACRB_OFS_OUTPUT_MODE 12'h014
`define ACRB_OFS_USER_PATT2_HIGH 12'h01C
`define ACRB_OFS_SERIAL_FRAMING 12'h021
`define ACRB_OFS_CHANNEL_STATUS 12'h022
`define ACRB_OFS_TRANSFER 12'h0FF
`define ACRB_OFS_RATE_OVERRIDE 12'h100
`define ACRB_OFS_IO_PULLDOWN 12'h101
`define ACRB_OFS_IO_COMMON_MODE 12'h102
`define ACRB_OFS_SYNC 12'h109
`define ACRB_RST_CHANNEL_SELECT 8'h3F
`define ACRB_RST_POWER_MODE 8'h00
`define ACRB_RST_ENHANCEMENT 8'h00
`define ACRB_RST_OUTPUT_MODE 8'h01
`define ACRB_RST_ZERO 8'h00
`define ACRB_RST_SERIAL_FRAMING 8'h30
`define ACRB_PM_NORMAL 2'h0
`define ACRB_PM_POWER_DOWN 2'h1
`define ACRB_PM_STANDBY 2'h2
`define ACRB_PM_DIGITAL_RESET 2'h3
`define ACRB_BIT_PIN_FUNCTION 5
`define ACRB_BIT_CHOP 2
`define ACRB_BIT_IEEE_RANGE 6
`define ACRB_BIT_INVERT 2
`define ACRB_BIT_TWOS 0
`define ACRB_BIT_COMMIT 0
`define ACRB_BIT_LSB_FIRST 7
`define ACRB_BIT_DOUBLE_FRAME 2
`define ACRB_BIT_OVR_ENABLE 6
`define ACRB_BIT_CH_POWER_DOWN 0
`define ACRB_BIT_CH_OUT_RESET 1
`define ACRB_BIT_SYNC_ENABLE 0
`define ACRB_BIT_SYNC_NEXT 1
`define ACRB_BIT_PULLDOWN_OFF 0
`define ACRB_BIT_CM_POWER_DOWN 3
`endif

// ===== hdl/acrb_control_bank.v
// Control register bank of a four-channel converter, serial-port side
`timescale 1ns/1ns
`default_nettype none
`include "acrb_map.vh"
module acrb_control_bank #(
  parameter CHANNELS = 4 // Data channels
) (
  // Clock and power-on reset
  input wire clk_i, // Converter clock
  input wire rst_i, // Power-on reset, sync, active high
  // Register access from the serial port
  input wire wr_i, // Register write strobe
  input wire rd_i, // Register read strobe
  input wire [11:0] addr_i, // Register address
  input wire [7:0] wdata_i, // Write data
  // External power-down pin
  input wire power_down_pin_i, // External power-down pin, active high
  // Read data back to the host
  output reg [7:0] rdata_o, // Read data
  // Per channel controls
  output reg [CHANNELS-1:0] ch_power_down_o, // Per channel power-down
  output reg [CHANNELS-1:0] ch_out_reset_o, // Per channel output reset
  output reg [CHANNELS-1:0] ch_invert_o, // Per channel stream invert
  // Power mode controls
  output reg datapath_clk_en_o, // Datapath clocks running
  output reg datapath_reset_o, // Datapath held in reset
  output reg outputs_en_o, // Output drivers enabled
  // Global conversion and framing controls
  output reg chop_en_o, // First-stage chopping
  output reg ieee_range_o, // Reduced-range LVDS
  output reg twos_complement_o, // Sample format
  output reg lsb_first_o, // Bit order
  output reg double_frame_o, // 2x frame mode
  output reg [2:0] lane_mode_o, // Lane and rate mode
  output reg word_12bit_o, // Serial word 12 bits
  output reg [3:0] clk_ratio_o, // Bit clock to sample ratio
  // Pattern byte and committed override
  output reg [7:0] user_pattern_two_high_o, // User pattern 2 upper byte
  output reg ovr_enable_o, // Committed override enable
  output reg [1:0] ovr_resolution_o, // Committed resolution code
  output reg [2:0] ovr_rate_o, // Committed rate code
  // Serial pin, common mode and sync controls
  output reg pulldown_off_o, // Serial data pull-down disabled
  output reg common_mode_generator_off_o, // Common mode generator off
  output reg sync_en_o, // External sync enable
  output reg sync_next_only_o // Sync on next event only
);
  // Block overview
  // Host writes and reads one byte per strobe
  // Twelve-bit address, byte-wide registers
  // No wait states, no refused requests
  // Back-to-back accesses in any order
  // Reads answer one edge after the strobe
  // Derived controls follow one edge later still
  // Four data channels share the global settings
  // Channel mask steers the local settings
  // Pin and field together pick the power mode
  // Override settings wait for a commit strobe
  // Serial access survives every power mode
  // Power-on reset is the only way to clear it
  // Framing decode gives word, lanes and ratio
  // Register map of the bank
  // 0x005 channel mask for local writes
  // 0x008 power mode field and pin function
  // 0x00C chop enable
  // 0x014 output standard, invert, format
  // 0x01C user pattern two, upper byte
  // 0x021 serial framing, default 16-bit DDR
  // 0x022 per channel power-down and reset
  // 0x0FF commit strobe for the override
  // 0x100 staged resolution and rate override
  // 0x101 serial data pull-down control
  // 0x102 common mode generator control
  // 0x109 external sync control
  // Anything else reads zero, writes dropped
  // Register storage
  reg [7:0] channel_select; // Channel mask
  reg [7:0] power_mode_control; // Power mode
  reg [7:0] enhancement_control; // Chop control
  reg [7:0] output_mode_control; // Global output bits
  reg [7:0] user_pattern_two_high; // Pattern byte
  reg [7:0] serial_output_framing; // Framing control
  reg [7:0] transfer_commit; // Commit bit, self clearing
  reg [7:0] resolution_rate_override; // Staged override
  reg [7:0] io_control_pulldown; // Pull-down control
  reg [7:0] io_control_common_mode; // Common mode control
  reg [7:0] sync_control; // Sync control
  reg [CHANNELS-1:0] ch_pd; // Local channel power-down
  reg [CHANNELS-1:0] ch_rst; // Local channel output reset
  reg [CHANNELS-1:0] ch_inv; // Local channel invert
  reg [1:0] eff_mode; // Mode after pin override
  reg [7:0] next_rdata; // Read mux
  reg [3:0] next_ratio; // Decoded clock ratio
  wire [CHANNELS-1:0] sel; // Selected channels
  wire wr_local_status; // Local status write
  wire wr_local_mode; // Local output mode write
  integer i;

  // Selected channel mask from low bits
  assign sel = channel_select[CHANNELS-1:0];
  assign wr_local_status = wr_i && (addr_i == `ACRB_OFS_CHANNEL_STATUS);
  assign wr_local_mode = wr_i && (addr_i == `ACRB_OFS_OUTPUT_MODE);

  // Write path
  // One write per strobe, address and data taken together
  // Global registers apply to every channel at once
  // Local fields land only where the channel mask is set
  // Channel mask is the value before this write
  // Open bits are stored as zero
  // Unmapped addresses leave every register untouched
  // Commit strobe stands one cycle, then clears
  // A commit write wins over the self clear
  // Override contents stay staged until a commit
  // No power mode reaches this process
  // Only the power-on reset clears the bank
  // Register writes, immediate except override
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel_select <= `ACRB_RST_CHANNEL_SELECT;
      power_mode_control <= `ACRB_RST_POWER_MODE;
      enhancement_control <= `ACRB_RST_ENHANCEMENT;
      output_mode_control <= `ACRB_RST_OUTPUT_MODE;
      user_pattern_two_high <= `ACRB_RST_ZERO;
      serial_output_framing <= `ACRB_RST_SERIAL_FRAMING;
      transfer_commit <= `ACRB_RST_ZERO;
      resolution_rate_override <= `ACRB_RST_ZERO;
      io_control_pulldown <= `ACRB_RST_ZERO;
      io_control_common_mode <= `ACRB_RST_ZERO;
      sync_control <= `ACRB_RST_ZERO;
      ch_pd <= {CHANNELS{1'b0}};
      ch_rst <= {CHANNELS{1'b0}};
      ch_inv <= {CHANNELS{1'b0}};
    end else begin
      // Commit bit clears itself the cycle after it is set
      transfer_commit <= 8'h00;
      if (wr_i) begin
        case (addr_i)
          `ACRB_OFS_CHANNEL_SELECT: channel_select <= wdata_i;
          `ACRB_OFS_POWER_MODE: power_mode_control <= wdata_i & 8'h23;
          `ACRB_OFS_ENHANCEMENT: enhancement_control <= wdata_i & 8'h04;
          `ACRB_OFS_OUTPUT_MODE: output_mode_control <= wdata_i & 8'h41;
          `ACRB_OFS_USER_PATT2_HIGH: user_pattern_two_high <= wdata_i;
          `ACRB_OFS_SERIAL_FRAMING: serial_output_framing <= wdata_i & 8'hF7;
          `ACRB_OFS_TRANSFER: transfer_commit <= wdata_i & 8'h01;
          `ACRB_OFS_RATE_OVERRIDE: resolution_rate_override <= wdata_i & 8'h77;
          `ACRB_OFS_IO_PULLDOWN: io_control_pulldown <= wdata_i & 8'h01;
          `ACRB_OFS_IO_COMMON_MODE: io_control_common_mode <= wdata_i & 8'h08;
          `ACRB_OFS_SYNC: sync_control <= wdata_i & 8'h03;
          default: begin
            // Unmapped or local, handled below
          end
        endcase
      end
      // Local registers touch only selected channels
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (sel[i] && wr_local_status) begin
          ch_pd[i] <= wdata_i[`ACRB_BIT_CH_POWER_DOWN];
          ch_rst[i] <= wdata_i[`ACRB_BIT_CH_OUT_RESET];
        end
        if (sel[i] && wr_local_mode) begin
          ch_inv[i] <= wdata_i[`ACRB_BIT_INVERT];
        end
      end
    end
  end

  // Read path
  // Address decoded in the strobe cycle
  // Data flopped, stands until the next read
  // Local fields read back channel 0 only
  // Output mode read merges channel 0 invert
  // Unmapped addresses read as zero
  // Read mux; local registers show channel 0
  always @* begin
    next_rdata = 8'h00;
    case (addr_i)
      `ACRB_OFS_CHANNEL_SELECT: next_rdata = channel_select;
      `ACRB_OFS_POWER_MODE: next_rdata = power_mode_control;
      `ACRB_OFS_ENHANCEMENT: next_rdata = enhancement_control;
      `ACRB_OFS_OUTPUT_MODE: next_rdata = output_mode_control | {5'h00, ch_inv[0], 2'h0};
      `ACRB_OFS_USER_PATT2_HIGH: next_rdata = user_pattern_two_high;
      `ACRB_OFS_SERIAL_FRAMING: next_rdata = serial_output_framing;
      `ACRB_OFS_CHANNEL_STATUS: next_rdata = {6'h00, ch_rst[0], ch_pd[0]};
      `ACRB_OFS_TRANSFER: next_rdata = transfer_commit;
      `ACRB_OFS_RATE_OVERRIDE: next_rdata = resolution_rate_override;
      `ACRB_OFS_IO_PULLDOWN: next_rdata = io_control_pulldown;
      `ACRB_OFS_IO_COMMON_MODE: next_rdata = io_control_common_mode;
      `ACRB_OFS_SYNC: next_rdata = sync_control;
      default: next_rdata = 8'h00;
    endcase
  end

  // Power mode selection
  // Pin low: register field used as written
  // Pin high, function bit set: power-down
  // Pin high, function bit clear: standby
  // Mode 11 keeps clocks, resets datapath
  // Serial access unaffected in every mode
  // Effective power mode, pin overrides register field
  always @* begin
    eff_mode = power_mode_control[1:0];
    if (power_down_pin_i) begin
      if (power_mode_control[`ACRB_BIT_PIN_FUNCTION]) begin
        eff_mode = `ACRB_PM_POWER_DOWN;
      end else begin
        eff_mode = `ACRB_PM_STANDBY;
      end
    end
  end

  // Bit clock to sample clock ratio for a lane mode and word length
  function [3:0] ratio_of;
    input [2:0] lanes; // Lane and rate mode field
    input twelve; // Word is 12 bits
    begin
      case (lanes)
        // DDR two-lane, bitwise or bytewise
        3'h2, 3'h3: ratio_of = twelve ? 4'h3 : 4'h4;
        // SDR two-lane, bitwise or bytewise
        3'h0, 3'h1: ratio_of = twelve ? 4'h6 : 4'h8;
        // DDR one-lane
        3'h4: ratio_of = twelve ? 4'h6 : 4'h8;
        // Reserved codes fall back to the default ratio
        default: ratio_of = 4'h4;
      endcase
    end
  endfunction

  // Bit clock ratio from lane mode and word length
  always @* begin
    next_ratio = ratio_of(serial_output_framing[6:4], serial_output_framing[1]);
  end

  // Output stage
  // Every port leaves a flop of its own
  // Derived controls trail their register by one edge
  // Reset gives normal mode with outputs live
  // Reset gives ANSI levels and twos complement
  // Reset framing is 16-bit two-lane DDR, ratio four
  // Power-down mode forces every channel down
  // Otherwise channel bits follow the local fields
  // Override ports load only on the commit strobe
  // They hold through every later override write
  // Pattern, pin and sync bits copy their registers
  // Read data changes only on a read strobe
  // Output flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      ch_power_down_o <= {CHANNELS{1'b0}};
      ch_out_reset_o <= {CHANNELS{1'b0}};
      ch_invert_o <= {CHANNELS{1'b0}};
      datapath_clk_en_o <= 1'b1;
      datapath_reset_o <= 1'b0;
      outputs_en_o <= 1'b1;
      chop_en_o <= 1'b0;
      ieee_range_o <= 1'b0;
      twos_complement_o <= 1'b1;
      lsb_first_o <= 1'b0;
      double_frame_o <= 1'b0;
      lane_mode_o <= 3'h3;
      word_12bit_o <= 1'b0;
      clk_ratio_o <= 4'd4;
      user_pattern_two_high_o <= 8'h00;
      ovr_enable_o <= 1'b0;
      ovr_resolution_o <= 2'h0;
      ovr_rate_o <= 3'h0;
      pulldown_off_o <= 1'b0;
      common_mode_generator_off_o <= 1'b0;
      sync_en_o <= 1'b0;
      sync_next_only_o <= 1'b0;
    end else begin
      // Read data captured on the strobe
      if (rd_i) begin
        rdata_o <= next_rdata;
      end
      // Power mode decode
      case (eff_mode)
        `ACRB_PM_NORMAL: begin
          datapath_clk_en_o <= 1'b1;
          datapath_reset_o <= 1'b0;
          outputs_en_o <= 1'b1;
        end
        `ACRB_PM_POWER_DOWN: begin
          datapath_clk_en_o <= 1'b0;
          datapath_reset_o <= 1'b1;
          outputs_en_o <= 1'b0;
        end
        `ACRB_PM_STANDBY: begin
          datapath_clk_en_o <= 1'b0;
          datapath_reset_o <= 1'b0;
          outputs_en_o <= 1'b0;
        end
        default: begin
          datapath_clk_en_o <= 1'b1;
          datapath_reset_o <= 1'b1;
          outputs_en_o <= 1'b0;
        end
      endcase
      // Channel controls, power-down mode forces all
      ch_power_down_o <= ch_pd | {CHANNELS{eff_mode == `ACRB_PM_POWER_DOWN}};
      ch_out_reset_o <= ch_rst;
      ch_invert_o <= ch_inv;
      // Global conversion controls
      chop_en_o <= enhancement_control[`ACRB_BIT_CHOP];
      ieee_range_o <= output_mode_control[`ACRB_BIT_IEEE_RANGE];
      twos_complement_o <= output_mode_control[`ACRB_BIT_TWOS];
      // Framing decode
      lsb_first_o <= serial_output_framing[`ACRB_BIT_LSB_FIRST];
      double_frame_o <= serial_output_framing[`ACRB_BIT_DOUBLE_FRAME];
      lane_mode_o <= serial_output_framing[6:4];
      word_12bit_o <= serial_output_framing[1];
      clk_ratio_o <= next_ratio;
      user_pattern_two_high_o <= user_pattern_two_high;
      // Override applied only on commit
      if (transfer_commit[`ACRB_BIT_COMMIT]) begin
        ovr_enable_o <= resolution_rate_override[`ACRB_BIT_OVR_ENABLE];
        ovr_resolution_o <= resolution_rate_override[5:4];
        ovr_rate_o <= resolution_rate_override[2:0];
      end
      // Pin and sync controls
      pulldown_off_o <= io_control_pulldown[`ACRB_BIT_PULLDOWN_OFF];
      common_mode_generator_off_o <= io_control_common_mode[`ACRB_BIT_CM_POWER_DOWN];
      sync_en_o <= sync_control[`ACRB_BIT_SYNC_ENABLE];
      sync_next_only_o <= sync_control[`ACRB_BIT_SYNC_NEXT];
    end
  end
endmodule // acrb_control_bank
`default_nettype wire

// ===== tb/acrb_checker_sva.sv
// Assertion checker for the converter control bank ports
`timescale 1ns/1ns
`default_nettype none
module acrb_checker #(parameter CHANNELS = 4) (
  input wire clk_i, input wire rst_i, input wire wr_i, input wire power_down_pin_i,
  input wire [11:0] addr_i, input wire [7:0] wdata_i,
  input wire [CHANNELS-1:0] ch_power_down_o, input wire [CHANNELS-1:0] ch_out_reset_o,
  input wire datapath_clk_en_o, input wire datapath_reset_o, input wire outputs_en_o,
  input wire chop_en_o, input wire ieee_range_o, input wire twos_complement_o,
  input wire [2:0] lane_mode_o, input wire word_12bit_o, input wire [3:0] clk_ratio_o,
  input wire ovr_enable_o, input wire [1:0] ovr_resolution_o, input wire [2:0] ovr_rate_o);
  reg [7:0] sel; // Shadow of channel selection
  reg [1:0] pm; // Shadow of power mode field
  reg pfn; // Shadow of pin function bit
  // Shadow registers follow host writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      sel <= 8'h3F;
      pm <= 2'h0;
      pfn <= 1'b0;
    end else if (wr_i && addr_i == 12'h005) begin
      sel <= wdata_i;
    end else if (wr_i && addr_i == 12'h008) begin
      pm <= wdata_i[1:0];
      pfn <= wdata_i[5];
    end
  end
  // Pin overrides the field while high
  wire [1:0] em = power_down_pin_i ? (pfn ? 2'h1 : 2'h2) : pm;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_mode_normal: assert property (
    (em == 2'h0)[*3] |-> datapath_clk_en_o && !datapath_reset_o && outputs_en_o)
    else $error("normal mode controls wrong");
  a_mode_power_down: assert property (
    (em == 2'h1)[*3] |-> !datapath_clk_en_o && datapath_reset_o && !outputs_en_o
    && &ch_power_down_o) else $error("power-down controls wrong");
  a_mode_standby: assert property (
    (em == 2'h2)[*3] |-> !datapath_clk_en_o && !datapath_reset_o && !outputs_en_o)
    else $error("standby controls wrong");
  a_mode_dig_reset: assert property (
    (em == 2'h3)[*3] |-> datapath_reset_o && !outputs_en_o) else $error("reset mode wrong");
  a_commit_only: assert property (
    $changed({ovr_enable_o, ovr_resolution_o, ovr_rate_o})
    |-> $past(wr_i && addr_i == 12'h0FF && wdata_i[0], 2))
    else $error("override changed without commit");
  a_chop_follows: assert property (
    wr_i && addr_i == 12'h00C |-> ##2 chop_en_o == $past(wdata_i[2], 2))
    else $error("chop bit not applied");
  a_format_global: assert property (
    wr_i && addr_i == 12'h014 |-> ##2 ieee_range_o == $past(wdata_i[6], 2)
    && twos_complement_o == $past(wdata_i[0], 2)) else $error("output mode not applied");
  a_framing_decode: assert property (
    clk_ratio_o == (lane_mode_o > 3'h4 ? 4'h4 : lane_mode_o[2:1] == 2'h1
    ? (word_12bit_o ? 4'h3 : 4'h4) : (word_12bit_o ? 4'h6 : 4'h8)))
    else $error("bit clock ratio wrong");
  a_local_mask: assert property (
    wr_i && addr_i == 12'h022 |-> ##2 ch_out_reset_o == (($past(ch_out_reset_o)
    & ~$past(sel[CHANNELS-1:0], 2)) | ({CHANNELS{$past(wdata_i[1], 2)}}
    & $past(sel[CHANNELS-1:0], 2)))) else $error("channel mask not honoured");
endmodule // acrb_checker
bind acrb_control_bank acrb_checker #(.CHANNELS(CHANNELS)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .wr_i(wr_i), .power_down_pin_i(power_down_pin_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .ch_power_down_o(ch_power_down_o), .ch_out_reset_o(ch_out_reset_o),
  .datapath_clk_en_o(datapath_clk_en_o), .datapath_reset_o(datapath_reset_o),
  .outputs_en_o(outputs_en_o), .chop_en_o(chop_en_o), .ieee_range_o(ieee_range_o),
  .twos_complement_o(twos_complement_o), .lane_mode_o(lane_mode_o),
  .word_12bit_o(word_12bit_o), .clk_ratio_o(clk_ratio_o), .ovr_enable_o(ovr_enable_o),
  .ovr_resolution_o(ovr_resolution_o), .ovr_rate_o(ovr_rate_o));
`default_nettype wire

// ===== tb/acrb_host.sv
// Serial-port host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module acrb_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [11:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 12'h000;
    wdata_o = 8'h00;
  end
  // One write; released lines show the inverse so stale values never match
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // One read; data is taken a cycle after the read edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule // acrb_host
`default_nettype wire

// ===== tb/acrb_control_bank_tb_top.sv
// Self-checking bench for the converter control bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module acrb_control_bank_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, power_down_pin_i = 1'b0; // Bench-driven inputs
  wire wr_i, rd_i, datapath_clk_en_o, datapath_reset_o, outputs_en_o, chop_en_o, ieee_range_o;
  wire twos_complement_o, lsb_first_o, double_frame_o, word_12bit_o, ovr_enable_o;
  wire pulldown_off_o, common_mode_generator_off_o, sync_en_o, sync_next_only_o;
  wire [11:0] addr_i;
  wire [7:0] wdata_i, rdata_o, user_pattern_two_high_o;
  wire [3:0] ch_power_down_o, ch_out_reset_o, ch_invert_o, clk_ratio_o;
  wire [2:0] lane_mode_o, ovr_rate_o;
  wire [1:0] ovr_resolution_o;
  logic [7:0] d; // Read result
  int n_errors = 0, checks_done = 0, cycles = 0;
  logic [11:0] ra [13] = '{12'h005, 12'h008, 12'h00C, 12'h014, 12'h01C, 12'h021, 12'h022,
    12'h0FF, 12'h100, 12'h101, 12'h102, 12'h109, 12'h0FE};
  logic [7:0] rv [13] = '{8'h3F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [11:0] wa [6] = '{12'h01C, 12'h101, 12'h102, 12'h109, 12'h0FE, 12'h00C};
  logic [7:0] we [6] = '{8'hA5, 8'h01, 8'h08, 8'h03, 8'h00, 8'h04};
  logic [7:0] fv [6] = '{8'h30, 8'h22, 8'h14, 8'h40, 8'h02, 8'hB4};
  logic [9:0] fe [6] = '{10'h064, 10'h053, 10'h128, 10'h088, 10'h016, 10'h364};
  logic [7:0] mv [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h00};
  logic mp [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [2:0] me [6] = '{3'h5, 3'h2, 3'h0, 3'h6, 3'h2, 3'h0};
  acrb_control_bank uut (.*);
  acrb_host h (.clk_i(clk_i), .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  // Free-running clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      h.rd(ra[i], d);
      `CHK(d, rv[i])
    end
    `CHK({twos_complement_o, clk_ratio_o, lane_mode_o}, 8'hA3)
    for (int i = 0; i < 6; i++) begin
      h.wr(wa[i], 8'hFF);
      h.rd(wa[i], d);
      `CHK(d, (i == 0) ? 8'hFF : we[i])
    end
    `CHK({pulldown_off_o, common_mode_generator_off_o, sync_en_o, sync_next_only_o}, 4'hF)
    `CHK(chop_en_o, 1'b1)
    h.wr(12'h005, 8'h05);
    h.wr(12'h01C, 8'hA5);
    h.wr(12'h022, 8'h03);
    h.wr(12'h014, 8'h45);
    repeat (2) @(posedge clk_i);
    `CHK({ch_power_down_o, ch_out_reset_o, ch_invert_o, ieee_range_o}, 13'h0AAB)
    `CHK(user_pattern_two_high_o, 8'hA5)
    h.wr(12'h005, 8'h0F);
    h.wr(12'h022, 8'h00);
    h.wr(12'h014, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK({ch_power_down_o, ch_out_reset_o, ch_invert_o, twos_complement_o}, 13'h0000)
    h.wr(12'h100, 8'h52);
    repeat (3) @(posedge clk_i);
    `CHK({ovr_enable_o, ovr_resolution_o, ovr_rate_o}, 6'h00)
    h.wr(12'h0FF, 8'h01);
    repeat (3) @(posedge clk_i);
    `CHK({ovr_enable_o, ovr_resolution_o, ovr_rate_o}, 6'h2A)
    for (int i = 0; i < 6; i++) begin
      h.wr(12'h021, fv[i]);
      repeat (2) @(posedge clk_i);
      `CHK({lsb_first_o, double_frame_o, lane_mode_o, word_12bit_o, clk_ratio_o}, fe[i])
    end
    for (int i = 0; i < 6; i++) begin
      power_down_pin_i <= mp[i];
      h.wr(12'h008, mv[i]);
      repeat (3) @(posedge clk_i);
      `CHK({datapath_clk_en_o, datapath_reset_o, outputs_en_o}, me[i])
      h.rd(12'h01C, d);
      `CHK(d, 8'hA5)
    end
    power_down_pin_i <= 1'b0;
    end_sim();
  end
endmodule // acrb_control_bank_tb_top
`default_nettype wire
